// file: rtl/lpw_pkg.sv
// package of constants and carriers for the low-power mode and wake control
// Behaviour
// - sleep on wait instr when low-power and deep sleep bits clear
// - sleep wakes on irq or event by entry
// - wait mode on event instr, low-power set, deep sleep clear
// - wait mode stops clocks, keeps supplies on
// - wait wakes on fast inputs, rtc, rtt, usb
// - backup on event instr with deep sleep set
// - backup domain keeps slow logic running
// - slow oscillator chosen by software setting
// - force wake pin low, debounced, leaves backup
// - enabled wake input transition, debounced, leaves backup
// - supply monitor, rtc, rtt alarms leave backup
// - backup wake runs core supply restart sequence
// - parts and wake sources individually enabled
// - low level on wake input starts fast
// - fast start-up request is synchronised, clocked path
// - fast start restarts rc, switches clock, core
// - active clock from rc, crystal or pll
package lpw_pkg;
   // ------------------------------------------------------------
   // register map (word aligned byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] LPW_CTRL_ADDR   = 8'h00; // mode bits, clock selects
   localparam logic [7:0] LPW_WKEN_ADDR   = 8'h04; // wake source enables
   localparam logic [7:0] LPW_FSEN_ADDR   = 8'h08; // fast start-up input enables
   localparam logic [7:0] LPW_DEB_ADDR    = 8'h0c; // debounce lengths
   localparam logic [7:0] LPW_STAT_ADDR   = 8'h10; // wake cause and debounced wake levels
   localparam logic [7:0] LPW_PCLK_ADDR   = 8'h14; // peripheral clock enables
   // ------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------
   localparam int LPW_CTRL_LPS    = 0;  // low_power_select
   localparam int LPW_CTRL_DSS    = 1;  // deep_sleep_select
   localparam int LPW_CTRL_SLOSC  = 2;  // slow osc: 0 rc, 1 crystal
   localparam int LPW_CTRL_RCEN   = 3;  // fast_rc_osc_enable
   localparam int LPW_CTRL_MCKLO  = 4;  // main clock select low bit
   // wake enable positions: [15:0] inputs, then these
   localparam int LPW_WK_FORCE_WAKE_PIN     = 16;
   localparam int LPW_WK_SMON     = 17;
   localparam int LPW_WK_RTC      = 18;
   localparam int LPW_WK_RTT      = 19;
   localparam int LPW_WK_USB      = 20;
   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [31:0] LPW_CTRL_RST  = 32'h0000_0008;
   localparam logic [31:0] LPW_WKEN_RST  = 32'h0000_0000;
   localparam logic [31:0] LPW_FSEN_RST  = 32'h0000_0000;
   localparam logic [31:0] LPW_DEB_RST   = 32'h0000_0303;
   localparam logic [31:0] LPW_PCLK_RST  = 32'hffff_ffff;
   localparam int LPW_SEQ_NS    = 1000;  // core supply restart step time
   localparam int LPW_CLK_MHZ   = 20;
   localparam int LPW_SEQ_CYC   = (LPW_SEQ_NS * LPW_CLK_MHZ + 999) / 1000;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {LPW_CLK_RC, LPW_CLK_XTAL, LPW_CLK_PLL} lpw_mck_type;
   typedef enum {LPW_ACTIVE, LPW_SLEEP, LPW_WAIT, LPW_BACKUP,
                 LPW_SUPPLY_UP, LPW_RESTART} lpw_mode_type;
   typedef struct packed {
      logic        wait_for_interrupt_instr;    // wait_for_interrupt_instr pulse
      logic        wait_for_event_instr;    // wait_for_event_instr pulse
      logic        irq;    // pending interrupt
      logic        evt;    // pending event
   } lpw_core_type;
   typedef struct packed {
      logic        smon;   // supply_monitor alarm
      logic        rtc;
      logic        real_time_timer;
      logic        usb;
   } lpw_alarm_type;
   typedef struct packed {
      logic        core_clk_en;
      logic        per_clk_en;
      logic        mem_clk_en;
      logic        reg_on;        // regulator_shutdown_ctl, 1 = on
      logic        core_rst;      // hold core in reset
      logic        slow_xtal;     // slow osc selection
      logic        rc_on;         // fast rc running
      logic [1:0]  mck_sel;       // master clock select
   } lpw_pwr_type;
endpackage : lpw_pkg

// file: rtl/lpw_ctrl.sv
// low-power mode decode, wake sources and supply sequencing
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module lpw_ctrl #(
   parameter int NWAKE = 16,  // wake input count
   parameter int DEBW  = 8    // debounce counter width
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // wishbone slave
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [7:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   // core requests
   input  wire lpw_pkg::lpw_core_type core_i,
   // pins and alarms (asynchronous)
   input  wire logic                 force_wake_pin_i,
   input  wire logic [NWAKE-1:0]     wake_inputs_i,
   input  wire lpw_pkg::lpw_alarm_type alarm_i,
   // power and clock controls
   output lpw_pkg::lpw_pwr_type      pwr_o,
   output logic                      fast_start_o,
   output logic [31:0]               per_clk_en_o
);
   import lpw_pkg::*;

   initial begin
      if (NWAKE != 16) $error("lpw_ctrl: NWAKE must be 16");
      if (DEBW < 2 || DEBW > 8) $error("lpw_ctrl: DEBW out of range");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0]       ctrl;
      logic [31:0]       wken;
      logic [31:0]       fsen;
      logic [31:0]       deb;
      logic [31:0]       pclk;
      logic [31:0]       dat;
      logic              ack;
      lpw_mode_type      mode;
      logic              by_wfi;      // sleep entered by wfi
      logic [NWAKE:0]    s1;          // sync stage 1 (pin + inputs)
      logic [NWAKE:0]    s2;          // sync stage 2
      logic [3:0]        a1;          // alarm sync stage 1
      logic [3:0]        a2;          // alarm sync stage 2
      logic [NWAKE-1:0]  wk_stable;   // debounced wake levels
      logic [DEBW-1:0]   wk_cnt;      // shared input debounce counter
      logic [DEBW-1:0]   fw_cnt;      // force wake debounce counter
      logic [7:0]        seq_cnt;     // supply sequence timer
      logic [4:0]        wake_src;    // last wake cause
      logic              fast;
      lpw_pwr_type       pwr;
   } lpw_state_type;

   lpw_state_type st_reg, st_next;

   // full-word write with byte enables
   function automatic logic [31:0] lpw_wr(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction : lpw_wr

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   logic              bus_req;     // new access
   logic [NWAKE-1:0]  wk_lvl;      // synced wake inputs
   logic              fw_low;      // synced force wake low
   logic [3:0]        alm;         // synced alarms
   logic              fs_any;      // fast start-up condition
   logic              bk_wake;     // backup exit condition
   logic              wt_wake;     // wait exit condition
   logic              cpu_run;     // core clocked

   always_comb begin
      st_next = st_reg;
      bus_req = cyc_i && stb_i && !st_reg.ack;
      // two-flop synchronisers
      st_next.s1 = {force_wake_pin_i, wake_inputs_i};
      st_next.s2 = st_reg.s1;
      st_next.a1 = {alarm_i.smon, alarm_i.rtc, alarm_i.real_time_timer, alarm_i.usb};
      st_next.a2 = st_reg.a1;
      wk_lvl = st_reg.s2[NWAKE-1:0];
      fw_low = !st_reg.s2[NWAKE];
      alm    = st_reg.a2 & {st_reg.wken[LPW_WK_SMON], st_reg.wken[LPW_WK_RTC],
                            st_reg.wken[LPW_WK_RTT], st_reg.wken[LPW_WK_USB]};

      // wake input transitions must hold for the debounce time
      if ((wk_lvl ^ st_reg.wk_stable) != '0) begin
         if (st_reg.wk_cnt == st_reg.deb[DEBW-1:0]) begin
            st_next.wk_stable = wk_lvl;
            st_next.wk_cnt    = '0;
         end else begin
            st_next.wk_cnt = st_reg.wk_cnt + 1'b1;
         end
      end else begin
         st_next.wk_cnt = '0;
      end
      // force wake low level debounce
      if (fw_low && st_reg.wken[LPW_WK_FORCE_WAKE_PIN]) begin
         if (st_reg.fw_cnt != st_reg.deb[8 +: DEBW]) st_next.fw_cnt = st_reg.fw_cnt + 1'b1;
      end else begin
         st_next.fw_cnt = '0;
      end

      // low level on any enabled fast input, taken from the two-flop synchronised levels
      fs_any = |(~wk_lvl & st_reg.fsen[NWAKE-1:0]) || (fw_low && st_reg.fsen[NWAKE]);
      wt_wake = fs_any || alm[2] || alm[1] || alm[0];
      bk_wake = (st_reg.fw_cnt == st_reg.deb[8 +: DEBW] && st_reg.wken[LPW_WK_FORCE_WAKE_PIN])
             || |((wk_lvl ^ st_reg.wk_stable) & st_reg.wken[NWAKE-1:0]
                  & {NWAKE{st_reg.wk_cnt == st_reg.deb[DEBW-1:0]}})
             || alm[3] || alm[2] || alm[1];

      st_next.fast = 1'b0;
      // mode machine
      unique case (st_reg.mode)
         LPW_ACTIVE: begin
            st_next.pwr.mck_sel = st_reg.ctrl[LPW_CTRL_MCKLO +: 2];
            st_next.pwr.rc_on   = st_reg.ctrl[LPW_CTRL_RCEN];
            if (core_i.wait_for_event_instr && st_reg.ctrl[LPW_CTRL_DSS]) begin
               st_next.mode = LPW_BACKUP;
            end else if (core_i.wait_for_event_instr && st_reg.ctrl[LPW_CTRL_LPS]) begin
               st_next.mode = LPW_WAIT;
            end else if (core_i.wait_for_interrupt_instr || core_i.wait_for_event_instr) begin
               st_next.mode   = LPW_SLEEP;
               st_next.by_wfi = core_i.wait_for_interrupt_instr;
            end
         end
         LPW_SLEEP: begin
            if (st_reg.by_wfi ? core_i.irq : core_i.evt) begin
               st_next.mode = LPW_ACTIVE;
            end
         end
         LPW_WAIT: begin
            if (wt_wake) begin
               // restart rc, switch master clock and core clock, all in one cycle
               st_next.fast        = 1'b1;
               st_next.pwr.rc_on   = 1'b1;
               st_next.pwr.mck_sel = LPW_CLK_RC;
               st_next.ctrl[LPW_CTRL_MCKLO +: 2] = LPW_CLK_RC;
               st_next.ctrl[LPW_CTRL_LPS] = 1'b0;
               st_next.wake_src = {fs_any, alm};
               st_next.mode = LPW_ACTIVE;
            end
         end
         LPW_BACKUP: begin
            if (bk_wake) begin
               st_next.wake_src = {fw_low, alm};
               st_next.seq_cnt  = '0;
               st_next.mode     = LPW_SUPPLY_UP;
            end
         end
         LPW_SUPPLY_UP: begin
            st_next.seq_cnt = st_reg.seq_cnt + 1'b1;
            if (st_reg.seq_cnt == 8'(LPW_SEQ_CYC)) begin
               st_next.seq_cnt = '0;
               st_next.mode    = LPW_RESTART;
            end
         end
         LPW_RESTART: begin
            // core reset released, runs from fast rc
            st_next.ctrl[LPW_CTRL_DSS] = 1'b0;
            st_next.ctrl[LPW_CTRL_LPS] = 1'b0;
            st_next.ctrl[LPW_CTRL_MCKLO +: 2] = LPW_CLK_RC;
            st_next.pwr.rc_on   = 1'b1;
            st_next.pwr.mck_sel = LPW_CLK_RC;
            st_next.mode        = LPW_ACTIVE;
         end
      endcase

      // power outputs per mode
      cpu_run = (st_next.mode == LPW_ACTIVE);
      st_next.pwr.core_clk_en = cpu_run;
      st_next.pwr.per_clk_en  = (st_next.mode == LPW_ACTIVE) || (st_next.mode == LPW_SLEEP);
      st_next.pwr.mem_clk_en  = st_next.pwr.per_clk_en;
      // regulator back on for the whole restart sequence, core held until active
      st_next.pwr.reg_on      = !(st_next.mode == LPW_BACKUP);
      st_next.pwr.core_rst    = (st_next.mode == LPW_BACKUP || st_next.mode == LPW_SUPPLY_UP
                                 || st_next.mode == LPW_RESTART);
      // slow oscillator choice stays live through backup
      st_next.pwr.slow_xtal   = st_reg.ctrl[LPW_CTRL_SLOSC];
      if (st_next.mode == LPW_WAIT) st_next.pwr.rc_on = 1'b0;

      // wishbone slave, one wait cycle then ack
      st_next.ack = bus_req;
      if (bus_req && we_i) begin
         unique case (adr_i)
            LPW_CTRL_ADDR: st_next.ctrl = lpw_wr(st_reg.ctrl, dat_i, sel_i);
            LPW_WKEN_ADDR: st_next.wken = lpw_wr(st_reg.wken, dat_i, sel_i);
            LPW_FSEN_ADDR: st_next.fsen = lpw_wr(st_reg.fsen, dat_i, sel_i);
            LPW_DEB_ADDR:  st_next.deb  = lpw_wr(st_reg.deb,  dat_i, sel_i);
            LPW_PCLK_ADDR: st_next.pclk = lpw_wr(st_reg.pclk, dat_i, sel_i);
            default: ;
         endcase
      end
      if (bus_req) begin
         unique case (adr_i)
            LPW_CTRL_ADDR: st_next.dat = st_reg.ctrl;
            LPW_WKEN_ADDR: st_next.dat = st_reg.wken;
            LPW_FSEN_ADDR: st_next.dat = st_reg.fsen;
            LPW_DEB_ADDR:  st_next.dat = st_reg.deb;
            LPW_STAT_ADDR: st_next.dat = {11'h000, st_reg.wake_src, st_reg.wk_stable};
            LPW_PCLK_ADDR: st_next.dat = st_reg.pclk;
            default:       st_next.dat = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg      <= '0;
         st_reg.ctrl <= LPW_CTRL_RST;
         st_reg.wken <= LPW_WKEN_RST;
         st_reg.fsen <= LPW_FSEN_RST;
         st_reg.deb  <= LPW_DEB_RST;
         st_reg.pclk <= LPW_PCLK_RST;
         st_reg.mode <= LPW_ACTIVE;
         st_reg.s1   <= '1;
         st_reg.s2   <= '1;
         st_reg.wk_stable   <= '1;
         st_reg.pwr.reg_on  <= 1'b1;
         st_reg.pwr.rc_on   <= 1'b1;
         st_reg.pwr.core_clk_en <= 1'b1;
         st_reg.pwr.per_clk_en  <= 1'b1;
         st_reg.pwr.mem_clk_en  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // outputs from flops; per_clk_en_o gated by per_clk_en
   // ------------------------------------------------------------
   assign dat_o        = st_reg.dat;
   assign ack_o        = st_reg.ack;
   assign pwr_o        = st_reg.pwr;
   assign fast_start_o = st_reg.fast;
   assign per_clk_en_o = st_reg.pclk & {32{st_reg.pwr.per_clk_en}};
endmodule : lpw_ctrl

// file: testbench/lpw_ctrl_chk_sva.sv
// assertion checker for the low-power mode and wake control
`timescale 1ns/1ps
module lpw_ctrl_chk
   import lpw_pkg::*;
#(parameter int NWAKE = 16, parameter int DEBW = 8)
(
   // clock, reset and bus
   input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i, dat_o,
   // core, pins and controls
   input wire lpw_pkg::lpw_core_type core_i,
   input wire logic force_wake_pin_i, fast_start_o,
   input wire logic [NWAKE-1:0] wake_inputs_i,
   input wire lpw_pkg::lpw_alarm_type alarm_i,
   input wire lpw_pkg::lpw_pwr_type pwr_o,
   input wire logic [31:0] per_clk_en_o
);
   localparam int SEQ_LO = LPW_SEQ_CYC + 1; // supply-up span bounds
   localparam int SEQ_HI = LPW_SEQ_CYC + 3;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // form of the last wait instruction, 1 = interrupt form
   logic ent_wfi_reg;
   always_ff @(posedge clk_i) begin
      if (core_i.wait_for_interrupt_instr || core_i.wait_for_event_instr) ent_wfi_reg <= core_i.wait_for_interrupt_instr;
   end
   AST_WB_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus request not acked for one cycle");
   AST_SLEEP_IN: assert property (core_i.wait_for_interrupt_instr && pwr_o.core_clk_en && !pwr_o.core_rst
      |=> !pwr_o.core_clk_en) else $error("core clock still on after wait instruction");
   AST_SLEEP_OUT: assert property (!pwr_o.core_clk_en && pwr_o.per_clk_en &&
      !pwr_o.core_rst && (ent_wfi_reg ? core_i.irq : core_i.evt) |=> pwr_o.core_clk_en)
      else $error("sleep not left on matching wake kind");
   AST_WAIT_CLK: assert property (!pwr_o.per_clk_en && pwr_o.reg_on && !pwr_o.core_rst
      |-> !pwr_o.core_clk_en && !pwr_o.mem_clk_en) else $error("clock left on in wait");
   AST_PCLK_GATE: assert property (!pwr_o.per_clk_en |-> per_clk_en_o == 32'h0)
      else $error("peripheral clock enable not gated");
   AST_FAST: assert property (fast_start_o |-> (pwr_o.core_clk_en && pwr_o.rc_on &&
      pwr_o.mck_sel == 2'h0) ##1 !fast_start_o) else $error("fast start state wrong");
   AST_BACKUP: assert property (!pwr_o.reg_on |-> pwr_o.core_rst)
      else $error("core not held while supply off");
   AST_SUPPLY: assert property ($rose(pwr_o.reg_on) |-> ##[SEQ_LO:SEQ_HI] $fell(pwr_o.core_rst))
      else $error("supply restart sequence length wrong");
   AST_RESTART: assert property ($fell(pwr_o.core_rst) |-> pwr_o.reg_on &&
      pwr_o.rc_on && pwr_o.mck_sel == 2'h0) else $error("core released in wrong state");
endmodule : lpw_ctrl_chk
bind lpw_ctrl lpw_ctrl_chk #(.NWAKE(NWAKE), .DEBW(DEBW)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .core_i(core_i), .force_wake_pin_i(force_wake_pin_i),
   .fast_start_o(fast_start_o), .wake_inputs_i(wake_inputs_i), .alarm_i(alarm_i),
   .pwr_o(pwr_o), .per_clk_en_o(per_clk_en_o));

// file: testbench/lpw_far_mdl.sv
// far-side model: core wait instructions, wake pins and alarms
`timescale 1ns/1ps
module lpw_far_mdl
   import lpw_pkg::*;
(
   // clock
   input  wire logic              clk_i,
   // core requests, pins and alarms
   output lpw_pkg::lpw_core_type  core_o,
   output logic                   force_wake_pin_o,
   output logic [15:0]            wake_inputs_o,
   output lpw_pkg::lpw_alarm_type alarm_o
);
   // idle: no request, pins high, alarms low
   initial begin
      core_o = '0;
      force_wake_pin_o = 1'b1;
      wake_inputs_o = 16'hffff;
      alarm_o = '0;
   end
   // one-cycle wait instruction, ev 1 = event form
   task automatic exec(input logic ev);
      @(posedge clk_i);
      core_o.wait_for_event_instr <= ev;
      core_o.wait_for_interrupt_instr <= ~ev;
      @(posedge clk_i);
      core_o.wait_for_event_instr <= 1'b0;
      core_o.wait_for_interrupt_instr <= 1'b0;
   endtask : exec
   // 0-15 input, 16 pin, 17-20 alarm, 21 irq, 22 event; on means waking level
   task automatic set_src(input int idx, input logic on);
      @(posedge clk_i);
      if (idx < 16) wake_inputs_o[idx] <= ~on;
      else if (idx == 16) force_wake_pin_o <= ~on;
      else if (idx < 21) alarm_o[20-idx] <= on;
      else core_o[22-idx] <= on;
   endtask : set_src
endmodule : lpw_far_mdl

// file: testbench/testbench.sv
// self-checking bench for the low-power mode and wake control
`timescale 1ns/1ps
module testbench;
   import lpw_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, force_wake_pin_i, fast_start_o;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, per_clk_en_o, rd;
   logic [15:0] wake_inputs_i;
   lpw_core_type core_i;
   lpw_alarm_type alarm_i;
   lpw_pwr_type pwr_o;
   int n_errors, tests_run, cyc_cnt, i;
   lpw_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .core_i(core_i), .force_wake_pin_i(force_wake_pin_i), .wake_inputs_i(wake_inputs_i),
      .alarm_i(alarm_i), .pwr_o(pwr_o), .fast_start_o(fast_start_o),
      .per_clk_en_o(per_clk_en_o));
   lpw_far_mdl mdl (.clk_i(clk_i), .core_o(core_i), .force_wake_pin_o(force_wake_pin_i),
      .wake_inputs_o(wake_inputs_i), .alarm_o(alarm_i));
   // 20 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // hang guard, several times the expected run
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 8000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one classic cycle, read data kept in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   // reset values, unmapped place, control fields
   task automatic t_reset;
      check(pwr_o, 32'h1e4);
      wb(1'b0, LPW_DEB_ADDR, 32'h0);
      check(rd, LPW_DEB_RST);
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      wb(1'b0, 8'h3c, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, LPW_CTRL_ADDR, 32'h0000_002c);
      wt(2);
      check({pwr_o.slow_xtal, pwr_o.mck_sel}, 32'h6);
      wb(1'b1, LPW_CTRL_ADDR, LPW_CTRL_RST);
      $display("reset test done");
   endtask : t_reset
   // sleep by each wait form; wrong wake kind ignored
   task automatic t_sleep;
      for (int k = 0; k < 2; k++) begin
         mdl.exec(k[0]);
         wt(2);
         check(pwr_o[8:7], 32'h1);
         mdl.set_src(22 - k, 1'b1);
         wt(4);
         check(pwr_o.core_clk_en, 32'h0);
         mdl.set_src(21 + k, 1'b1);
         wt(3);
         check(pwr_o.core_clk_en, 32'h1);
         mdl.set_src(21 + k, 1'b0);
         mdl.set_src(22 - k, 1'b0);
      end
      $display("sleep test done");
   endtask : t_sleep
   // wait mode left by fast input and rtc, rtt, usb alarms; disabled input ignored
   task automatic t_wait;
      wb(1'b1, LPW_PCLK_ADDR, 32'h0000_00a5);
      wb(1'b1, LPW_FSEN_ADDR, 32'h0000_0008);
      wb(1'b1, LPW_WKEN_ADDR, 32'h001c_0000);
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, LPW_CTRL_ADDR, 32'h0000_0009);
         wb(1'b0, LPW_CTRL_ADDR, 32'h0);
         check(rd[0], 32'h1);
         mdl.exec(1'b1);
         wt(2);
         check(pwr_o[8:5], 32'h1);
         mdl.set_src(2, 1'b1);
         wt(6);
         check(per_clk_en_o, 32'h0);
         mdl.set_src((k == 0) ? 3 : 17 + k, 1'b1);
         for (i = 0; i < 12 && fast_start_o !== 1'b1; i++) @(posedge clk_i);
         check({fast_start_o, pwr_o.core_clk_en, pwr_o.rc_on, pwr_o.mck_sel}, 32'h1c);
         check(per_clk_en_o, 32'h0000_00a5);
         wb(1'b0, LPW_CTRL_ADDR, 32'h0);
         check(rd[5:4], 32'h0);
         mdl.set_src(2, 1'b0);
         mdl.set_src((k == 0) ? 3 : 17 + k, 1'b0);
      end
      $display("wait test done");
   endtask : t_wait
   // backup left by pin, input and alarms; supply restart
   task automatic t_backup;
      int s;
      wb(1'b1, LPW_DEB_ADDR, 32'h0000_0202);
      for (int k = 0; k < 5; k++) begin
         s = (k == 0) ? 16 : (k == 1) ? 0 : 15 + k;
         wb(1'b1, LPW_WKEN_ADDR, 32'h1 << s);
         wb(1'b1, LPW_CTRL_ADDR, 32'h0000_000a);
         mdl.exec(1'b1);
         mdl.set_src(5, 1'b1);
         wt(12);
         check({pwr_o.reg_on, pwr_o.core_rst}, 32'h1);
         mdl.set_src(s, 1'b1);
         for (i = 0; i < 40 && pwr_o.reg_on !== 1'b1; i++) @(posedge clk_i);
         for (i = 0; i < 40 && pwr_o.core_rst !== 1'b0; i++) @(posedge clk_i);
         check({i > LPW_SEQ_CYC, pwr_o.core_rst}, 32'h2);
         wb(1'b0, LPW_CTRL_ADDR, 32'h0);
         check(rd[1:0], 32'h0);
         mdl.set_src(s, 1'b0);
         mdl.set_src(5, 1'b0);
      end
      $display("backup test done");
   endtask : t_backup
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   initial begin
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      sel_i = 4'hf;
      rst_i = 1'b1;
      wt(20);
      rst_i <= 1'b0;
      t_reset;
      t_sleep;
      t_wait;
      t_backup;
      end_sim();
   end
endmodule : testbench
